//--- hdl/swv_sequencer.sv
// Write-with-verify sequencer with bus-parity retry and operation timers.
// Assumes a target phase engine that selects, runs one command and reports.
// Assumes the host retries failed requests and asks for any block reassignment.
// Timer limits are counted in ticks of one shared prescaler.
module swv_sequencer #(
  parameter int unsigned TICK_CYC     = swv_pkg::TICK_CYC,
  parameter int unsigned SEL_TO_TICKS = swv_pkg::SEL_TO_TICKS,
  parameter int unsigned GLB_DEFAULT  = swv_pkg::GLB_TO_TICKS
) (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                rst_b,
  // Reset diagnostic result
  input  wire logic                diagFault,
  // Global timeout setting
  input  wire logic                setGlbValid,
  input  wire logic [31:0]         setGlbTicks,
  // Host request
  input  wire logic                reqValid,
  output logic                     reqReady,
  input  wire swv_pkg::swv_req_t   req,
  // Completion
  output logic                     doneValid,
  output swv_pkg::swv_err_t        doneErr,
  output logic [7:0]               intStatus,
  // Target command port
  output logic                     tcmdValid,
  input  wire logic                tcmdReady,
  output swv_pkg::swv_tcmd_t       tcmd,
  output logic                     tabort,
  input  wire swv_pkg::swv_tresp_t tresp
);
  // Sequencer states
  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_ISSUE  = 3'b001,
    S_SELECT = 3'b010,
    S_RUN    = 3'b011,
    S_DONE   = 3'b100
  } swv_state_t;

  // Selecting or running: the target holds the bus
  function automatic logic inTargetPhase(input swv_state_t s);
    return (s == S_SELECT) || (s == S_RUN);
  endfunction : inTargetPhase

  // A host command is in flight and its global timer runs
  function automatic logic inCommand(input swv_state_t s);
    return (s == S_ISSUE) || (s == S_SELECT) || (s == S_RUN);
  endfunction : inCommand

  // Interrupt status value for a completion code
  function automatic logic [7:0] statusFor(input swv_pkg::swv_err_t e);
    if (e == swv_pkg::ERR_NONE)
      return swv_pkg::ST_OK;
    else if (e == swv_pkg::ERR_LENGTH)
      return swv_pkg::ST_CMD_ERR;
    else
      return swv_pkg::ST_DEV_ERR;
  endfunction : statusFor

  swv_state_t        state_q;
  swv_pkg::swv_req_t req_q;
  swv_pkg::swv_op_t  op_q;
  logic [3:0]        parCnt_q;
  logic              parRetried_q;
  logic [31:0]       tickDiv_q;
  logic              tick;
  logic [31:0]       selCnt_q;
  logic [31:0]       glbCnt_q;
  logic [31:0]       glbLimit_q;
  logic              selExpired;
  logic              glbExpired;
  logic              finish;
  swv_pkg::swv_err_t finErr;
  logic              tooLong;
  logic              parityLast;
  logic              targetDone;
  logic              refuse;
  logic              report;

  assign tick       = (tickDiv_q == TICK_CYC - 1);
  assign selExpired = (state_q == S_SELECT) && (selCnt_q >= SEL_TO_TICKS);
  assign glbExpired = inCommand(state_q) && (glbCnt_q >= glbLimit_q);
  assign tooLong    = (req.blockCount > 16'(swv_pkg::MAX_BLOCKS)) ||
                      (64'(req.byteCount) > swv_pkg::MAX_BYTES);
  assign reqReady   = (state_q == S_IDLE);
  assign tcmdValid  = (state_q == S_ISSUE);
  assign tcmd       = '{op: op_q, lba: req_q.lba, blockCount: req_q.blockCount};
  assign tabort     = finish && inTargetPhase(state_q);
  assign parityLast = parRetried_q || req_q.disableRetry ||
                      (parCnt_q + 4'h1 >= 4'(swv_pkg::PAR_LIMIT));

  // Qualifiers shared by several processes
  assign targetDone = inTargetPhase(state_q) && tresp.done;
  assign refuse     = (state_q == S_IDLE) && reqValid && tooLong;
  assign report     = inCommand(state_q) && finish;

  // Completion decision for the running command
  always_comb
  begin
    finish = 1'b0;
    finErr = swv_pkg::ERR_NONE;
    if (glbExpired)
    begin
      finish = 1'b1;
      finErr = swv_pkg::ERR_GLB_TO;
    end
    else if (selExpired)
    begin
      finish = 1'b1;
      finErr = swv_pkg::ERR_SEL_TO;
    end
    else if (targetDone)
    begin
      if (tresp.parityErr)
      begin
        finish = parityLast;
        finErr = swv_pkg::ERR_PARITY;
      end
      else if (tresp.formatErr)
      begin
        finish = 1'b1;
        finErr = swv_pkg::ERR_FORMAT;
      end
      else if (tresp.posnErr)
      begin
        finish = 1'b1;
        finErr = swv_pkg::ERR_POSN;
      end
      else if (!tresp.good)
      begin
        finish = 1'b1;
        finErr = swv_pkg::ERR_TARGET;
      end
      else if (op_q == swv_pkg::OP_VERIFY)
      begin
        finish = 1'b1;
      end
    end
  end

  // Prescaled tick
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      tickDiv_q <= '0;
    else if (tick)
      tickDiv_q <= '0;
    else
      tickDiv_q <= tickDiv_q + 32'h1;
  end

  // Selection timer, restarted for each selection
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      selCnt_q <= '0;
    else if (state_q != S_SELECT)
      selCnt_q <= '0;
    else if (tick)
      selCnt_q <= selCnt_q + 32'h1;
  end

  // Global timer, restarted for each command
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      glbCnt_q <= '0;
    else if (!inCommand(state_q))
      glbCnt_q <= '0;
    else if (tick)
      glbCnt_q <= glbCnt_q + 32'h1;
  end

  // Global timeout limit
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      glbLimit_q <= GLB_DEFAULT;
    else if (setGlbValid)
      glbLimit_q <= setGlbTicks;
  end

  // Sequencing state
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      state_q <= S_IDLE;
    else
      case (state_q)
        S_IDLE:
          if (reqValid && !tooLong)
            state_q <= S_ISSUE;
          else if (reqValid)
            state_q <= S_DONE;
        S_ISSUE:
          if (finish)
            state_q <= S_DONE;
          else if (tcmdReady)
            state_q <= S_SELECT;
        S_SELECT, S_RUN:
          if (finish)
            state_q <= S_DONE;
          else if (tresp.done)
            state_q <= S_ISSUE;
          else if (tresp.selected)
            state_q <= S_RUN;
        S_DONE:
          state_q <= S_IDLE;
        default:
          state_q <= S_IDLE;
      endcase
  end

  // Request capture and operation order
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      req_q <= '0;
      op_q  <= swv_pkg::OP_WRITE;
    end
    else if (state_q == S_IDLE && reqValid)
    begin
      req_q <= req;
      op_q  <= swv_pkg::OP_WRITE;
    end
    else if (targetDone && !finish &&
             !tresp.parityErr && tresp.good)
      op_q  <= swv_pkg::OP_VERIFY;
  end

  // Parity error accounting
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      parCnt_q     <= '0;
      parRetried_q <= 1'b0;
    end
    else if (state_q == S_IDLE)
    begin
      parCnt_q     <= '0;
      parRetried_q <= 1'b0;
    end
    else if (targetDone)
    begin
      if (tresp.parityErr)
      begin
        parCnt_q     <= parCnt_q + 4'h1;
        parRetried_q <= 1'b1;
      end
      else
        parRetried_q <= 1'b0;
    end
  end

  // Completion report
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      doneValid <= 1'b0;
      doneErr   <= swv_pkg::ERR_NONE;
    end
    else
    begin
      doneValid <= 1'b0;
      if (refuse)
      begin
        doneValid <= 1'b1;
        doneErr   <= swv_pkg::ERR_LENGTH;
      end
      else if (report)
      begin
        doneValid <= 1'b1;
        doneErr   <= finErr;
      end
    end
  end

  // Interrupt status, seeded from the reset diagnostic
  logic resetSeen_q;
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      intStatus   <= 8'h00;
      resetSeen_q <= 1'b0;
    end
    else if (!resetSeen_q)
    begin
      resetSeen_q <= 1'b1;
      intStatus   <= diagFault ? swv_pkg::ST_DIAG_FAIL : swv_pkg::ST_RESET_OK;
    end
    else if (refuse)
      intStatus <= statusFor(swv_pkg::ERR_LENGTH);
    else if (report)
      intStatus <= statusFor(finErr);
  end
endmodule : swv_sequencer

//--- common/swv_pkg.sv
// Constants and types for the write-with-verify command sequencer.
// Assumes one 250 MHz clock and a target-side phase engine outside.
// Functional notes
// - Write-verify request issues a Write, then a Verify after all blocks.
// - Requests allow up to 65535 blocks and up to 16MB minus one byte.
// - Subsystem never retries commands itself, whatever the retry option says.
// - No automatic block reassignment after persistent read or write errors.
// - Format error after target retries ends the command with error.
// - Positioning error after target retries ends the command with error.
// - Bus parity error repeats the failing bus sequence unless retries disabled.
// - Failed parity retry or nine parity errors ends command, nonrecoverable.
// - No selection answer within 260 ms gives a selection time-out error.
// - Global command timer, default 45 s, settable; expiry gives global time-out.
// - After reset, diagnostic fault reports 7F in interrupt status.
package swv_pkg;
  localparam int unsigned CLK_HZ        = 250_000_000;
  localparam int unsigned TICK_US       = 1;
  localparam int unsigned TICK_CYC      = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned SEL_TO_MS     = 260;
  localparam int unsigned SEL_TO_TICKS  = SEL_TO_MS * 1000 / TICK_US;
  localparam int unsigned GLB_TO_S      = 45;
  localparam int unsigned GLB_TO_TICKS  = GLB_TO_S * 1_000_000 / TICK_US;
  localparam int unsigned MAX_BLOCKS    = 65535;
  localparam int unsigned MB_BYTES      = 1_048_576;
  localparam longint unsigned MAX_BYTES = 64'(16) * MB_BYTES - 1;
  localparam int unsigned PAR_LIMIT     = 9;
  localparam logic [7:0] ST_OK          = 8'h1f;
  localparam logic [7:0] ST_RESET_OK    = 8'haf;
  localparam logic [7:0] ST_DIAG_FAIL   = 8'h7f;
  localparam logic [7:0] ST_CMD_ERR     = 8'hcf;
  localparam logic [7:0] ST_DEV_ERR     = 8'hef;

  typedef enum logic [3:0] {
    ERR_NONE    = 4'h0,
    ERR_FORMAT  = 4'h1,
    ERR_POSN    = 4'h2,
    ERR_PARITY  = 4'h3,
    ERR_SEL_TO  = 4'h4,
    ERR_GLB_TO  = 4'h5,
    ERR_LENGTH  = 4'h6,
    ERR_TARGET  = 4'h7
  } swv_err_t;

  typedef enum logic [1:0] {
    OP_WRITE  = 2'h0,
    OP_VERIFY = 2'h1
  } swv_op_t;

  typedef struct packed {
    logic [31:0] lba;
    logic [31:0] byteCount;
    logic [15:0] blockCount;
    logic        retryEnableOption;
    logic        disableRetry;
  } swv_req_t;

  typedef struct packed {
    swv_op_t     op;
    logic [31:0] lba;
    logic [15:0] blockCount;
  } swv_tcmd_t;

  typedef struct packed {
    logic     selected;
    logic     done;
    logic     good;
    logic     parityErr;
    logic     formatErr;
    logic     posnErr;
  } swv_tresp_t;
endpackage : swv_pkg

//--- testbench/swv_seq_monitor.sv
// Assertions on the write-verify sequencer ports.
// Bound to the sequencer; expects short timer parameters.
module swv_seq_monitor #(
  parameter int unsigned TICK_CYC     = 2,
  parameter int unsigned SEL_TO_TICKS = 20
) (
  // Clock and reset
  input wire logic                clock,
  input wire logic                rst_b,
  // Host side
  input wire logic                diagFault,
  input wire logic                reqValid,
  input wire logic                reqReady,
  input wire swv_pkg::swv_req_t   req,
  input wire logic                doneValid,
  input wire swv_pkg::swv_err_t   doneErr,
  input wire logic [7:0]          intStatus,
  // Target side
  input wire logic                tcmdValid,
  input wire logic                tcmdReady,
  input wire logic                tabort,
  input wire swv_pkg::swv_tcmd_t  tcmd,
  input wire swv_pkg::swv_tresp_t tresp
);
  localparam int SLO = (SEL_TO_TICKS - 1) * TICK_CYC;
  localparam int SHI = (SEL_TO_TICKS + 1) * TICK_CYC + 4;
  logic [31:0] selCnt_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Cycles since the last hand-over while unselected
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
      selCnt_q <= '0;
    else if (tcmdValid && tcmdReady)
      selCnt_q <= '0;
    else if (!tresp.selected)
      selCnt_q <= selCnt_q + 32'h1;
  resetDiag_a: assert property (!$past(rst_b) |=>
    intStatus == ($past(diagFault) ? 8'h7f : 8'haf)) else $error("reset status wrong");
  lenRefuse_a: assert property (reqValid && reqReady && req.byteCount > swv_pkg::MAX_BYTES |=>
    doneValid && doneErr == swv_pkg::ERR_LENGTH) else $error("length not refused");
  writeFirst_a: assert property (reqValid && reqReady && req.byteCount <= swv_pkg::MAX_BYTES |=>
    tcmdValid && tcmd.op == swv_pkg::OP_WRITE) else $error("write not first");
  goodStatus_a: assert property (doneValid && doneErr == swv_pkg::ERR_NONE |-> intStatus == 8'h1f)
    else $error("good status wrong");
  formatEnd_a: assert property (tresp.done && tresp.formatErr |=>
    doneValid && doneErr == swv_pkg::ERR_FORMAT) else $error("format not ended");
  posnEnd_a: assert property (tresp.done && tresp.posnErr |=>
    doneValid && doneErr == swv_pkg::ERR_POSN) else $error("position not ended");
  parityRetry_a: assert property (tresp.done && tresp.parityErr |=> ##[0:2]
    (tcmdValid || doneValid && doneErr == swv_pkg::ERR_PARITY)) else $error("parity not handled");
  noSelfRetry_a: assert property (doneValid |-> !tcmdValid ##1 !tcmdValid)
    else $error("command after completion");
  selTimer_a: assert property (doneValid && doneErr == swv_pkg::ERR_SEL_TO |->
    selCnt_q >= SLO && selCnt_q <= SHI) else $error("selection time-out length");
  selAbort_a: assert property (doneValid && doneErr == swv_pkg::ERR_SEL_TO |-> $past(tabort))
    else $error("selection not abandoned");
  blockSame_a: assert property (reqValid && reqReady |=> tcmd.lba == $past(req.lba) &&
    tcmd.blockCount == $past(req.blockCount)) else $error("target command fields wrong");
  cover property (doneValid && doneErr == swv_pkg::ERR_NONE);
  cover property (doneValid && doneErr == swv_pkg::ERR_PARITY);
  cover property (doneValid && doneErr == swv_pkg::ERR_GLB_TO);
endmodule : swv_seq_monitor

//--- testbench/swv_target_model.sv
// Behavioural target: selects, runs one command, reports.
// Faults only when the bench raises fail.
module swv_target_model (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                rst_b,
  // Scenario control
  input  wire logic [7:0]          lag,
  input  wire logic [2:0]          mode,
  input  wire logic                fail,
  // Command port
  input  wire logic                tcmdValid,
  output logic                     tcmdReady,
  input  wire swv_pkg::swv_tcmd_t  tcmd,
  input  wire logic                tabort,
  output swv_pkg::swv_tresp_t      tresp
);
  logic       busy_q;
  logic [7:0] cnt_q;
  assign tcmdReady = !busy_q;
  always @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      busy_q <= 1'b0;
      cnt_q  <= 8'h0;
      tresp  <= '0;
    end
    else
    begin
      tresp <= '{selected: tresp.selected, default: 1'b0};
      if (tcmdValid && !busy_q)
      begin
        busy_q <= 1'b1;
        cnt_q  <= lag;
      end
      else if (busy_q && tabort)
      begin
        busy_q <= 1'b0;
        tresp  <= '0;
      end
      else if (busy_q && cnt_q != 8'h0)
        cnt_q <= cnt_q - 8'h1;
      else if (busy_q && !tresp.selected && !(fail && mode == 3'h4))
      begin
        tresp.selected <= 1'b1;
        cnt_q          <= lag;
      end
      else if (busy_q && tresp.selected && !(fail && mode == 3'h5))
      begin
        busy_q <= 1'b0;
        tresp  <= '{selected: 1'b0, done: 1'b1, good: !fail, parityErr: fail && mode == 3'h1,
                    formatErr: fail && mode == 3'h2, posnErr: fail && mode == 3'h3};
      end
    end
endmodule : swv_target_model

//--- testbench/scsi_write_verify_error_recovery_tb_top.sv
// Bench for the write-verify sequencer against a behavioural target.
// Assumes short timer parameters so time-outs fit the run.
module scsi_write_verify_error_recovery_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clock = 1'b0;
  logic                rst_b = 1'b0;
  logic                diagFault = 1'b0;
  logic                setGlbValid = 1'b0;
  logic [31:0]         setGlbTicks = 32'h0;
  logic                reqValid = 1'b0;
  swv_pkg::swv_req_t   req = '0;
  logic [7:0]          lag = 8'h2;
  logic [2:0]          mode = 3'h0;
  logic [7:0]          cmds = 8'h0;
  logic [7:0]          nFail = 8'h0;
  logic [7:0]          cmdBase = 8'h0;
  logic [7:0]          firstOp;
  logic [7:0]          lastOp;
  logic                reqReady;
  logic                doneValid;
  logic                tcmdValid;
  logic                tcmdReady;
  logic                tabort;
  logic [7:0]          intStatus;
  swv_pkg::swv_err_t   doneErr;
  swv_pkg::swv_tcmd_t  tcmd;
  swv_pkg::swv_tresp_t tresp;
  int                  mismatches = 0;
  int                  tests_run = 0;
  always #2 clock = ~clock;
  always @(posedge clock)
    if (tcmdValid && tcmdReady)
    begin
      if (cmds == cmdBase)
        firstOp <= {6'h0, tcmd.op};
      lastOp <= {6'h0, tcmd.op};
      cmds   <= cmds + 8'h1;
    end
  swv_sequencer #(.TICK_CYC(2), .SEL_TO_TICKS(20), .GLB_DEFAULT(200)) u_swv_sequencer (.clock(clock),
    .rst_b(rst_b), .diagFault(diagFault), .setGlbValid(setGlbValid), .setGlbTicks(setGlbTicks),
    .reqValid(reqValid), .reqReady(reqReady), .req(req), .doneValid(doneValid), .doneErr(doneErr),
    .intStatus(intStatus), .tcmdValid(tcmdValid), .tcmdReady(tcmdReady), .tcmd(tcmd), .tabort(tabort),
    .tresp(tresp));
  swv_target_model u_swv_target_model (.clock(clock), .rst_b(rst_b), .lag(lag), .mode(mode),
    .fail((cmds - cmdBase) <= nFail), .tcmdValid(tcmdValid), .tcmdReady(tcmdReady), .tcmd(tcmd), .tabort(tabort),
    .tresp(tresp));
  task chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h got %h", what, exp, got);
    end
  endtask : chk8
  task chkErr(input string what, input swv_pkg::swv_err_t exp, input swv_pkg::swv_err_t got);
    chk8(what, {4'h0, exp}, {4'h0, got});
  endtask : chkErr
  task stop_test;
    $display("Checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task resetDut(input logic df);
    @(negedge clock);
    rst_b     = 1'b0;
    diagFault = df;
    repeat (10) @(negedge clock);
    rst_b = 1'b1;
    repeat (2) @(negedge clock);
  endtask : resetDut
  task run(input logic [31:0] bytes, input logic dis, input logic [2:0] m, input logic [7:0] nf,
           input swv_pkg::swv_err_t e, input logic [7:0] n);
    int i;
    cmdBase = cmds;
    nFail = nf;
    mode  = m;
    req   = '{lba: 32'h100, byteCount: bytes, blockCount: 16'hffff, retryEnableOption: 1'b1, disableRetry: dis};
    for (i = 0; i < 100 && reqReady !== 1'b1; i++)
      @(negedge clock);
    reqValid = 1'b1;
    @(negedge clock);
    reqValid = 1'b0;
    for (i = 0; i < 3000 && doneValid !== 1'b1; i++)
      @(negedge clock);
    if (i == 3000)
    begin
      mismatches++;
      $display("Error doneValid expected 1 got 0");
      stop_test();
    end
    chkErr("doneErr", e, doneErr);
    chk8("cmds", n, cmds - cmdBase);
    chk8("intStatus", e == swv_pkg::ERR_NONE ? 8'h1f : e == swv_pkg::ERR_LENGTH ? 8'hcf : 8'hef, intStatus);
    @(negedge clock);
  endtask : run
  task setGlb(input logic [31:0] t);
    setGlbTicks = t;
    setGlbValid = 1'b1;
    @(negedge clock);
    setGlbValid = 1'b0;
  endtask : setGlb
  task t_good;
    run(32'h200, 1'b0, 3'h0, 8'h0, swv_pkg::ERR_NONE, 8'h2);
    chk8("firstOp", {6'h0, swv_pkg::OP_WRITE}, firstOp);
    chk8("lastOp", {6'h0, swv_pkg::OP_VERIFY}, lastOp);
    lag = 8'h1e;
    run(32'h200, 1'b0, 3'h0, 8'h0, swv_pkg::ERR_NONE, 8'h2);
    lag = 8'h2;
  endtask : t_good
  task t_length;
    run(32'h00ff_ffff, 1'b0, 3'h0, 8'h0, swv_pkg::ERR_NONE, 8'h2);
    run(32'h0100_0000, 1'b0, 3'h0, 8'h0, swv_pkg::ERR_LENGTH, 8'h0);
  endtask : t_length
  task t_parity;
    run(32'h200, 1'b0, 3'h1, 8'h1, swv_pkg::ERR_NONE, 8'h3);
    run(32'h200, 1'b1, 3'h1, 8'h1, swv_pkg::ERR_PARITY, 8'h1);
    run(32'h200, 1'b0, 3'h1, 8'h2, swv_pkg::ERR_PARITY, 8'h2);
    run(32'h200, 1'b0, 3'h0, 8'h0, swv_pkg::ERR_NONE, 8'h2);
  endtask : t_parity
  task t_target;
    run(32'h200, 1'b0, 3'h2, 8'h9, swv_pkg::ERR_FORMAT, 8'h1);
    run(32'h200, 1'b0, 3'h3, 8'h9, swv_pkg::ERR_POSN, 8'h1);
  endtask : t_target
  task t_timers;
    run(32'h200, 1'b0, 3'h4, 8'h9, swv_pkg::ERR_SEL_TO, 8'h1);
    setGlb(32'h1e);
    run(32'h200, 1'b0, 3'h5, 8'h9, swv_pkg::ERR_GLB_TO, 8'h1);
    setGlb(32'hc8);
    run(32'h200, 1'b0, 3'h0, 8'h0, swv_pkg::ERR_NONE, 8'h2);
  endtask : t_timers
  task t_reset(input logic df, input logic [7:0] exp);
    resetDut(df);
    chk8("intStatus", exp, intStatus);
  endtask : t_reset
  initial
  begin
    t_reset(1'b0, 8'haf);
    t_good();
    t_length();
    t_parity();
    t_target();
    t_timers();
    t_reset(1'b1, 8'h7f);
    stop_test();
  end
endmodule : scsi_write_verify_error_recovery_tb_top
bind swv_sequencer swv_seq_monitor #(.TICK_CYC(TICK_CYC), .SEL_TO_TICKS(SEL_TO_TICKS)) u_swv_seq_monitor (
  .clock(clock), .rst_b(rst_b), .diagFault(diagFault), .reqValid(reqValid), .reqReady(reqReady),
  .req(req), .doneValid(doneValid), .doneErr(doneErr), .intStatus(intStatus), .tcmdValid(tcmdValid),
  .tcmdReady(tcmdReady), .tcmd(tcmd), .tabort(tabort), .tresp(tresp));
